// *** logic/dtd_decision.sv ***
// Differential protection trip decision with external fault stabilisation
`timescale 1ns/10ps
module dtd_decision #(
	parameter int QUAL_CYCLES = dtd_pkg::QUAL_CYCLES
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          ce_i,
	input  wire logic                          user_block_in_i,
	input  wire logic [dtd_pkg::NPH-1:0]       char_start_i,
	input  wire logic [dtd_pkg::NPH-1:0]       char_unr_start_i,
	input  wire logic [dtd_pkg::NPH-1:0]       harm2_restraint_i,
	input  wire logic [dtd_pkg::NPH-1:0]       harm5_restraint_i,
	input  wire logic [dtd_pkg::MAG_W-1:0]     bias_ph1_i,
	input  wire logic [dtd_pkg::MAG_W-1:0]     bias_ph2_i,
	input  wire logic [dtd_pkg::MAG_W-1:0]     bias_ph3_i,
	input  wire logic [dtd_pkg::MAG_W-1:0]     diff_ph1_i,
	input  wire logic [dtd_pkg::MAG_W-1:0]     diff_ph2_i,
	input  wire logic [dtd_pkg::MAG_W-1:0]     diff_ph3_i,
	input  wire logic [dtd_pkg::ANG_W-1:0]     angle_diff_i,
	input  wire logic [dtd_pkg::ADDR_W-1:0]    avs_address_i,
	input  wire logic                          avs_read_i,
	input  wire logic                          avs_write_i,
	input  wire logic [dtd_pkg::DATA_W-1:0]    avs_writedata_i,
	input  wire logic [3:0]                    avs_byteenable_i,
	output logic      [dtd_pkg::DATA_W-1:0]    avs_readdata_o,
	output logic                               avs_waitrequest_o,
	output logic                               restrained_start_ph1_o,
	output logic                               restrained_start_ph2_o,
	output logic                               restrained_start_ph3_o,
	output logic                               restrained_start_any_o,
	output logic                               unrestrained_start_ph1_o,
	output logic                               unrestrained_start_ph2_o,
	output logic                               unrestrained_start_ph3_o,
	output logic                               unrestrained_start_any_o,
	output logic                               inrush_restraint_o,
	output logic                               fifth_harmonic_restraint_o,
	output logic                               harm2_enable_o,
	output logic                               adaptive_active_o,
	output logic      [dtd_pkg::PCT_W-1:0]     slope1_sel_o,
	output logic      [dtd_pkg::PCT_W-1:0]     slope2_sel_o
);
	localparam int NPH = dtd_pkg::NPH;

	if (QUAL_CYCLES < 1) begin : g_bad_qual
		$error("dtd_decision: QUAL_CYCLES must be at least 1");
	end

	// Register file
	logic [dtd_pkg::CFG_BYTES*8-1:0] cfg;
	logic [dtd_pkg::ST_W-1:0]        status;
	wire  [dtd_pkg::PCT_W-1:0]       base_sens;
	wire  [dtd_pkg::PCT_W-1:0]       set_slope1;
	wire  [dtd_pkg::PCT_W-1:0]       set_slope2;

	dtd_avmm_regs u_regs (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.ce_i          (ce_i),
		.address_i     (avs_address_i),
		.read_i        (avs_read_i),
		.write_i       (avs_write_i),
		.writedata_i   (avs_writedata_i),
		.byteenable_i  (avs_byteenable_i),
		.readdata_o    (avs_readdata_o),
		.waitrequest_o (avs_waitrequest_o),
		.status_i      (status),
		.cfg_o         (cfg)
	);

	assign base_sens  = cfg[dtd_pkg::CFG_BASE_LSB   +: dtd_pkg::PCT_W];
	assign set_slope1 = cfg[dtd_pkg::CFG_SLOPE1_LSB +: dtd_pkg::PCT_W];
	assign set_slope2 = cfg[dtd_pkg::CFG_SLOPE2_LSB +: dtd_pkg::PCT_W];

	// Adaptive characteristic qualification
	wire [dtd_pkg::MAG_W-1:0] bias [NPH];
	wire [dtd_pkg::MAG_W-1:0] diff [NPH];
	wire [NPH-1:0]            qual_cond;
	wire [NPH-1:0]            qual_done;
	wire [NPH-1:0]            bias_low;
	wire                      adapt_set;
	wire                      adapt_release;

	assign bias[0] = bias_ph1_i;
	assign bias[1] = bias_ph2_i;
	assign bias[2] = bias_ph3_i;
	assign diff[0] = diff_ph1_i;
	assign diff[1] = diff_ph2_i;
	assign diff[2] = diff_ph3_i;

	for (genvar p = 0; p < NPH; p++) begin : g_phase
		// Saturation shows as high bias while differential current is still below base sensitivity
		assign qual_cond[p] = (bias[p] > dtd_pkg::BIAS_SET_PCT) &&
		                      (diff[p] < {8'h00, base_sens});
		assign bias_low[p]  = bias[p] < dtd_pkg::BIAS_REL_PCT;

		dtd_qual_timer #(
			.CYCLES (QUAL_CYCLES)
		) u_timer (
			.clk_i  (clk_i),
			.rst_i  (rst_i),
			.ce_i   (ce_i),
			.cond_i (qual_cond[p]),
			.done_o (qual_done[p])
		);
	end

	assign adapt_set     = |qual_done;
	// Release needs every phase low, so one hot phase keeps it held
	assign adapt_release = &bias_low;

	dtd_pkg::dtd_adapt_t adapt_q;
	dtd_pkg::dtd_adapt_t adapt_d;

	always_comb begin
		adapt_d = adapt_q;
		case (adapt_q)
			dtd_pkg::ADAPT_IDLE: begin
				if (adapt_set) begin
					adapt_d = dtd_pkg::ADAPT_ACTIVE;
				end
			end
			dtd_pkg::ADAPT_ACTIVE: begin
				if (adapt_release && !adapt_set) begin
					adapt_d = dtd_pkg::ADAPT_IDLE;
				end
			end
			default: begin
				adapt_d = dtd_pkg::ADAPT_IDLE;
			end
		endcase
	end

	// Decision logic
	wire                       blk;
	wire                       adapt_next;
	wire                       h2_en;
	wire [NPH-1:0]             rstart_d;
	wire [NPH-1:0]             ustart_d;
	wire [NPH-1:0]             h2_active;
	wire [dtd_pkg::PCT_W-1:0]  slope1_d;
	wire [dtd_pkg::PCT_W-1:0]  slope2_d;

	assign blk        = user_block_in_i;
	assign adapt_next = (adapt_d == dtd_pkg::ADAPT_ACTIVE);
	assign h2_en      = angle_diff_i >= dtd_pkg::EXT_ANGLE_DEG;
	assign h2_active  = harm2_restraint_i & {NPH{h2_en}};
	assign rstart_d   = blk ? '0 : char_start_i;
	assign ustart_d   = blk ? '0 : char_unr_start_i;
	assign slope1_d   = adapt_next ? dtd_pkg::ADAPT_SLOPE1 : set_slope1;
	assign slope2_d   = adapt_next ? dtd_pkg::ADAPT_SLOPE2 : set_slope2;

	logic [NPH-1:0]            rstart_q;
	logic [NPH-1:0]            ustart_q;
	logic                      rany_q;
	logic                      uany_q;
	logic                      inrush_q;
	logic                      fifth_q;
	logic                      h2en_q;
	logic [dtd_pkg::PCT_W-1:0] slope1_q;
	logic [dtd_pkg::PCT_W-1:0] slope2_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adapt_q  <= dtd_pkg::ADAPT_IDLE;
			rstart_q <= '0;
			ustart_q <= '0;
			rany_q   <= 1'b0;
			uany_q   <= 1'b0;
			inrush_q <= 1'b0;
			fifth_q  <= 1'b0;
			h2en_q   <= 1'b0;
			slope1_q <= dtd_pkg::SLOPE1_RST;
			slope2_q <= dtd_pkg::SLOPE2_RST;
		end else if (ce_i) begin
			adapt_q  <= adapt_d;
			rstart_q <= rstart_d;
			ustart_q <= ustart_d;
			rany_q   <= |rstart_d;
			uany_q   <= |ustart_d;
			inrush_q <= !blk && (|h2_active);
			fifth_q  <= !blk && (|harm5_restraint_i);
			h2en_q   <= h2_en;
			slope1_q <= slope1_d;
			slope2_q <= slope2_d;
		end
	end

	assign restrained_start_ph1_o     = rstart_q[0];
	assign restrained_start_ph2_o     = rstart_q[1];
	assign restrained_start_ph3_o     = rstart_q[2];
	assign restrained_start_any_o     = rany_q;
	assign unrestrained_start_ph1_o   = ustart_q[0];
	assign unrestrained_start_ph2_o   = ustart_q[1];
	assign unrestrained_start_ph3_o   = ustart_q[2];
	assign unrestrained_start_any_o   = uany_q;
	assign inrush_restraint_o         = inrush_q;
	assign fifth_harmonic_restraint_o = fifth_q;
	assign harm2_enable_o             = h2en_q;
	assign adaptive_active_o          = (adapt_q == dtd_pkg::ADAPT_ACTIVE);
	assign slope1_sel_o               = slope1_q;
	assign slope2_sel_o               = slope2_q;

	// While blocked, status still shows the block, harm2 enable and adaptive bits; start and restraint bits read zero
	assign status = {blk, h2en_q, adaptive_active_o, fifth_q, inrush_q,
	                 uany_q, ustart_q, rany_q, rstart_q};

	a_block_quiet: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && user_block_in_i |=> !rany_q && !uany_q && rstart_q == '0 && ustart_q == '0
		&& !inrush_q && !fifth_q)
		else $error("decision output active while blocked");

	a_phase_start: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !user_block_in_i |=> rstart_q == $past(char_start_i))
		else $error("phase restrained start does not follow characteristic");

	a_any_start: assert property (
		@(posedge clk_i) disable iff (rst_i) rany_q == (|rstart_q))
		else $error("general restrained start mismatch");

	a_unr_phase: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !user_block_in_i |=> ustart_q == $past(char_unr_start_i))
		else $error("phase unrestrained start does not follow high setting");

	a_unr_any: assert property (
		@(posedge clk_i) disable iff (rst_i) uany_q == (|ustart_q))
		else $error("general unrestrained start mismatch");

	a_inrush_sum: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !user_block_in_i && h2_en && (|harm2_restraint_i) |=> inrush_q)
		else $error("inrush summary missing");

	a_fifth_sum: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !user_block_in_i |=> fifth_q == (|$past(harm5_restraint_i)))
		else $error("fifth harmonic summary mismatch");

	a_adapt_slopes: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && adapt_next |=> slope1_q == dtd_pkg::ADAPT_SLOPE1
		&& slope2_q == dtd_pkg::ADAPT_SLOPE2)
		else $error("adaptive slopes not selected");

	a_adapt_entry: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$rose(adaptive_active_o) |-> $past(adapt_set) && $past(ce_i))
		else $error("adaptive entered without qualified external fault");

	a_adapt_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$fell(adaptive_active_o) |-> $past(adapt_release))
		else $error("adaptive released while bias still high");

	a_adapt_set: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && adapt_set |=> adaptive_active_o)
		else $error("qualified condition did not set adaptive");

	a_harm2_gate: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && (angle_diff_i < dtd_pkg::EXT_ANGLE_DEG) |=> !inrush_q && !h2en_q)
		else $error("second harmonic restraint without angle condition");

	a_inrush_exact: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i |=> inrush_q == (!$past(user_block_in_i) && $past(h2_en)
		&& (|$past(harm2_restraint_i))))
		else $error("inrush summary does not match gated restraints");

	a_h2en_follow: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i |=> h2en_q == ($past(angle_diff_i) >= dtd_pkg::EXT_ANGLE_DEG))
		else $error("second harmonic enable does not follow angle");

	a_set_slopes: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !adapt_next |=> slope1_q == $past(set_slope1) && slope2_q == $past(set_slope2))
		else $error("set slopes not used outside adaptive mode");

	a_adapt_release: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && adaptive_active_o && adapt_release && !adapt_set |=> !adaptive_active_o)
		else $error("adaptive held after every bias fell low");

	a_no_early_set: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ce_i && !adaptive_active_o && !adapt_set |=> !adaptive_active_o)
		else $error("adaptive set before qualification expired");

endmodule

// *** logic/dtd_pkg.sv ***
// Constants and types shared by the differential trip decision block
package dtd_pkg;

	// Processing clock and qualification time
	localparam int CLK_FREQ_HZ = 40_000_000;
	localparam int T_QUAL_US   = 3000;
	localparam int QUAL_CYCLES = (T_QUAL_US * (CLK_FREQ_HZ / 1_000_000) + 0);

	// Widths
	localparam int NPH    = 3;
	localparam int MAG_W  = 16;
	localparam int PCT_W  = 8;
	localparam int ANG_W  = 8;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// Magnitudes are in percent of nominal current
	localparam logic [MAG_W-1:0] BIAS_SET_PCT = 16'h007D;
	localparam logic [MAG_W-1:0] BIAS_REL_PCT = 16'h0050;

	// Adaptive characteristic slopes, percent of bias current
	localparam logic [PCT_W-1:0] ADAPT_SLOPE1 = 8'h32;
	localparam logic [PCT_W-1:0] ADAPT_SLOPE2 = 8'hC8;

	// Least phase angle difference marking an external fault, degrees
	localparam logic [ANG_W-1:0] EXT_ANGLE_DEG = 8'h4B;

	// Setting reset values
	localparam logic [PCT_W-1:0] BASE_SENS_RST = 8'h14;
	localparam logic [PCT_W-1:0] SLOPE1_RST    = 8'h14;
	localparam logic [PCT_W-1:0] SLOPE2_RST    = 8'hC8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CFG    = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;

	// Configuration fields
	localparam int CFG_BASE_LSB   = 0;
	localparam int CFG_SLOPE1_LSB = 8;
	localparam int CFG_SLOPE2_LSB = 16;
	localparam int CFG_BYTES      = 3;

	// Status fields
	localparam int ST_RSTART_LSB = 0;
	localparam int ST_RANY       = 3;
	localparam int ST_USTART_LSB = 4;
	localparam int ST_UANY       = 7;
	localparam int ST_INRUSH     = 8;
	localparam int ST_FIFTH      = 9;
	localparam int ST_ADAPT      = 10;
	localparam int ST_H2EN       = 11;
	localparam int ST_BLOCK      = 12;
	localparam int ST_W          = 13;

	typedef enum logic [0:0] {
		ADAPT_IDLE   = 1'b0,
		ADAPT_ACTIVE = 1'b1
	} dtd_adapt_t;

endpackage

// *** logic/dtd_qual_timer.sv ***
// Restartable qualification timer for one phase
`timescale 1ns/10ps
module dtd_qual_timer #(
	parameter int CYCLES = 120000
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic cond_i,
	output logic      done_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES);

	if (CYCLES < 1) begin : g_bad_cycles
		$error("dtd_qual_timer: CYCLES must be at least 1");
	end

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// Any gap in the condition restarts the count from zero
	assign cnt_d  = !cond_i ? '0 : ((cnt_q == LAST) ? cnt_q : cnt_q + 1'b1);
	assign done_o = cond_i && (cnt_q == LAST);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else if (ce_i) begin
			cnt_q <= cnt_d;
		end
	end

	a_timer_restart: assert property (
		@(posedge clk_i) disable iff (rst_i) ce_i && !cond_i |=> cnt_q == '0)
		else $error("qualification timer did not restart");

endmodule

// *** logic/dtd_avmm_regs.sv ***
// Avalon-MM slave holding the settings and the status view
`timescale 1ns/10ps
module dtd_avmm_regs (
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	input  wire logic                              ce_i,
	input  wire logic [dtd_pkg::ADDR_W-1:0]        address_i,
	input  wire logic                              read_i,
	input  wire logic                              write_i,
	input  wire logic [dtd_pkg::DATA_W-1:0]        writedata_i,
	input  wire logic [3:0]                        byteenable_i,
	output logic      [dtd_pkg::DATA_W-1:0]        readdata_o,
	output logic                                   waitrequest_o,
	input  wire logic [dtd_pkg::ST_W-1:0]          status_i,
	output logic      [dtd_pkg::CFG_BYTES*8-1:0]   cfg_o
);
	logic                                 wait_q;
	logic                                 wait_d;
	logic [dtd_pkg::DATA_W-1:0]           rdata_q;
	logic [dtd_pkg::CFG_BYTES*8-1:0]      cfg_q;
	wire                                  req;
	wire                                  first;
	wire                                  ack_wr;
	wire                                  hit_cfg;
	wire                                  hit_st;
	wire  [dtd_pkg::DATA_W-1:0]           rd_mux;
	localparam logic [dtd_pkg::CFG_BYTES*8-1:0] CFG_RST = {
		dtd_pkg::SLOPE2_RST, dtd_pkg::SLOPE1_RST, dtd_pkg::BASE_SENS_RST};

	// Every request waits exactly one cycle, then completes
	assign req     = read_i || write_i;
	assign first   = req && wait_q;
	assign wait_d  = !first;
	assign ack_wr  = write_i && !wait_q;
	assign hit_cfg = (address_i == dtd_pkg::REG_CFG);
	assign hit_st  = (address_i == dtd_pkg::REG_STATUS);
	assign rd_mux  = hit_cfg ? {8'h00, cfg_q} :
	                 hit_st  ? {{(dtd_pkg::DATA_W-dtd_pkg::ST_W){1'b0}}, status_i} : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
		end else if (ce_i) begin
			wait_q <= wait_d;
			if (first && read_i) begin
				rdata_q <= rd_mux;
			end
		end
	end

	for (genvar b = 0; b < dtd_pkg::CFG_BYTES; b++) begin : g_lane
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cfg_q[b*8 +: 8] <= CFG_RST[b*8 +: 8];
			end else if (ce_i && ack_wr && hit_cfg && byteenable_i[b]) begin
				cfg_q[b*8 +: 8] <= writedata_i[b*8 +: 8];
			end
		end
	end

	assign readdata_o    = rdata_q;
	assign waitrequest_o = wait_q;
	assign cfg_o         = cfg_q;

endmodule

// *** verification/dtd_char_model.sv ***
// Upstream characteristic evaluation model driving the start flags
`timescale 1ns/10ps
module dtd_char_model #(
	parameter logic [15:0] UNR_PCT = 16'h0320
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [47:0] bias_i,
	input  wire logic [47:0] diff_i,
	input  wire logic [7:0]  slope_i,
	output logic      [2:0]  start_o,
	output logic      [2:0]  unr_start_o
);
	// Single slope through the origin; coarse, but it toggles both flags often
	always_ff @(posedge clk_i) begin
		for (int p = 0; p < 3; p++) begin
			start_o[p] <= !rst_i && (32'(diff_i[16*p+:16]) * 32'h0000_0064 >
				32'(bias_i[16*p+:16]) * 32'(slope_i));
			unr_start_o[p] <= !rst_i && (diff_i[16*p+:16] > UNR_PCT);
		end
	end
endmodule

// *** verification/dtd_decision_test.sv ***
// Self-checking bench for the differential trip decision block
`timescale 1ns/10ps
module dtd_decision_test;
	localparam int QUAL = 20;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        blk   = 1'b0;
	logic [2:0]  h2    = 3'h0;
	logic [2:0]  h5    = 3'h0;
	logic [47:0] bias  = 48'h0;
	logic [47:0] diff  = 48'h0;
	logic [7:0]  ang   = 8'h00;
	logic [3:0]  adr   = 4'h0;
	logic        rd    = 1'b0;
	logic        wr    = 1'b0;
	logic [31:0] wd    = 32'h0;
	logic [3:0]  be    = 4'h0;
	logic        chk   = 1'b0;
	logic [7:0]  base  = 8'h14;
	logic [7:0]  s1    = 8'h14;
	logic [7:0]  s2    = 8'hC8;
	logic        adp   = 1'b0;
	int          cnt[3] = '{0, 0, 0};
	int          seed  = 32'h987E7BC8;
	int          error_cnt = 0;
	int          compares  = 0;
	logic [2:0]  cst;
	logic [2:0]  ust;
	logic [11:0] fl;
	logic [7:0]  s1o;
	logic [7:0]  s2o;
	logic [31:0] rdata;
	logic        wait_o;
	logic [27:0] exp_q[$];
	logic [31:0] rd_q[$];

	initial begin
		forever #12.5 clk_i = !clk_i;
	end

	dtd_decision #(.QUAL_CYCLES(QUAL)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .user_block_in_i(blk),
		.char_start_i(cst), .char_unr_start_i(ust),
		.harm2_restraint_i(h2), .harm5_restraint_i(h5),
		.bias_ph1_i(bias[15:0]), .bias_ph2_i(bias[31:16]), .bias_ph3_i(bias[47:32]),
		.diff_ph1_i(diff[15:0]), .diff_ph2_i(diff[31:16]), .diff_ph3_i(diff[47:32]),
		.angle_diff_i(ang), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_o),
		.restrained_start_ph1_o(fl[0]), .restrained_start_ph2_o(fl[1]),
		.restrained_start_ph3_o(fl[2]), .restrained_start_any_o(fl[3]),
		.unrestrained_start_ph1_o(fl[4]), .unrestrained_start_ph2_o(fl[5]),
		.unrestrained_start_ph3_o(fl[6]), .unrestrained_start_any_o(fl[7]),
		.inrush_restraint_o(fl[8]), .fifth_harmonic_restraint_o(fl[9]),
		.harm2_enable_o(fl[10]), .adaptive_active_o(fl[11]),
		.slope1_sel_o(s1o), .slope2_sel_o(s2o)
	);

	dtd_char_model far (
		.clk_i(clk_i), .rst_i(rst_i), .bias_i(bias), .diff_i(diff),
		.slope_i(s1o), .start_o(cst), .unr_start_o(ust)
	);

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic cmp_flags(input string nm, input logic [7:0] e, input logic [7:0] g);
		check(nm, 32'(e), 32'(g));
	endtask

	task automatic cmp_slope(input logic [15:0] e, input logic [15:0] g);
		check("slopes", 32'(e), 32'(g));
	endtask

	task automatic cmp_read(input logic [31:0] e, input logic [31:0] g);
		check("readdata", e, g);
	endtask

	task automatic end_of_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Request held until waitrequest is seen low; the watchdog ends a hang
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] m, input logic [31:0] e);
		@(posedge clk_i);
		adr <= a;
		wd <= d;
		be <= m;
		rd <= !w;
		wr <= w;
		if (!w)
			rd_q.push_back(e);
		do begin
			@(posedge clk_i);
		end while (wait_o !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	// Expected outputs from the inputs the design samples at this edge
	always @(posedge clk_i) begin
		logic cond;
		logic set;
		logic low;
		logic [11:0] e;
		cond = 1'b0;
		set = 1'b0;
		low = 1'b1;
		// Each phase qualifies on its own; a gap restarts only that phase
		for (int p = 0; p < 3; p++) begin
			cond = bias[16*p+:16] > dtd_pkg::BIAS_SET_PCT && diff[16*p+:16] < 16'(base);
			set |= cond && cnt[p] >= QUAL;
			low &= bias[16*p+:16] < dtd_pkg::BIAS_REL_PCT;
			cnt[p] = (rst_i || !cond) ? 0 : cnt[p] + 1;
		end
		adp = !rst_i && (set || (adp && !low));
		e[3:0] = blk ? 4'h0 : {|cst, cst};
		e[7:4] = blk ? 4'h0 : {|ust, ust};
		e[8] = !blk && |h2 && ang >= dtd_pkg::EXT_ANGLE_DEG;
		e[9] = !blk && |h5;
		e[10] = ang >= dtd_pkg::EXT_ANGLE_DEG;
		e[11] = adp;
		if (chk)
			exp_q.push_back({adp ? {dtd_pkg::ADAPT_SLOPE1, dtd_pkg::ADAPT_SLOPE2} : {s1, s2}, e});
	end

	always @(negedge clk_i) begin
		logic [27:0] n;
		if (exp_q.size() > 0) begin
			n = exp_q.pop_front();
			cmp_flags("starts", n[7:0], fl[7:0]);
			cmp_flags("harm", 8'(n[10:8]), 8'(fl[10:8]));
			cmp_flags("adapt", 8'(n[11]), 8'(fl[11]));
			cmp_slope(n[27:12], {s1o, s2o});
		end
	end

	always @(posedge clk_i) begin
		if (rd && wait_o === 1'b0 && rd_q.size() > 0)
			cmp_read(rd_q.pop_front(), rdata);
	end

	initial begin
		repeat (3000) @(posedge clk_i);
		error_cnt++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		chk <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk <= 1'b0;
		bus(1'b0, dtd_pkg::REG_CFG, 32'h0, 4'hF, 32'h00C81414);
		bus(1'b1, dtd_pkg::REG_CFG, 32'h5A1E2A28, 4'h7, 32'h0);
		bus(1'b0, dtd_pkg::REG_CFG, 32'h0, 4'hF, 32'h001E2A28);
		bus(1'b1, dtd_pkg::REG_CFG, 32'hFFFF33FF, 4'h2, 32'h0);
		bus(1'b0, dtd_pkg::REG_CFG, 32'h0, 4'hF, 32'h001E3328);
		blk <= 1'b1;
		bus(1'b1, dtd_pkg::REG_STATUS, 32'hFFFFFFFF, 4'hF, 32'h0);
		bus(1'b0, dtd_pkg::REG_STATUS, 32'h0, 4'hF, 32'h00001000);
		bus(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF, 32'h0);
		bus(1'b0, 4'hC, 32'h0, 4'hF, 32'h00000000);
		blk <= 1'b0;
		base <= 8'h28;
		s1 <= 8'h33;
		s2 <= 8'h1E;
		repeat (4) @(posedge clk_i);
		chk <= 1'b1;
		// Bias kept below release level so only the gating logic moves
		repeat (400) begin
			@(posedge clk_i);
			blk <= ($random(seed) & 3) == 0;
			h2 <= 3'($random(seed));
			h5 <= 3'($random(seed));
			ang <= 8'($random(seed));
			for (int p = 0; p < 3; p++) begin
				bias[16*p+:16] <= 16'($unsigned($random(seed)) % dtd_pkg::BIAS_REL_PCT);
				diff[16*p+:16] <= 16'($unsigned($random(seed)) % 32'h0000_03E8);
			end
		end
		@(posedge clk_i);
		bias <= {16'h0000, 16'h00C8, 16'h0000};
		diff <= 48'h0;
		blk <= 1'b0;
		repeat (QUAL) @(posedge clk_i);
		diff[31:16] <= 16'(base);
		@(posedge clk_i);
		diff <= 48'h0;
		repeat (QUAL + 8) @(posedge clk_i);
		blk <= 1'b1;
		bias[31:16] <= 16'h0064;
		repeat (6) @(posedge clk_i);
		blk <= 1'b0;
		bias[31:16] <= 16'h004F;
		repeat (6) @(posedge clk_i);
		end_of_test();
	end
endmodule
